/* File: verilog/tcdma_pkg.sv */
// Package for the two-channel cycle-steal DMA controller.
// Assumes a 32-bit APB slave port and a 20-bit system bus.
package tcdma_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int CNT_W = 16;
  localparam int WAIT_W = 2;
  localparam int SEL_W = 5;
  // ----------------------------------------------------------------
  // Register byte offsets (channel 1 adds CH_STRIDE)
  // ----------------------------------------------------------------
  localparam logic [6:0] CH_STRIDE = 7'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_SEL = 5'h04;
  localparam logic [4:0] OFF_SRC = 5'h08;
  localparam logic [4:0] OFF_DST = 5'h0c;
  localparam logic [4:0] OFF_RLD = 5'h10;
  localparam logic [4:0] OFF_CNT = 5'h14;
  localparam logic [4:0] OFF_PTR = 5'h18;
  localparam logic [6:0] OFF_WAIT = 7'h40;
  // ----------------------------------------------------------------
  // Control and select fields
  // ----------------------------------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_PEND = 1;
  localparam int CTL_WORD = 2;
  localparam int CTL_REP = 3;
  localparam int CTL_SINC = 4;
  localparam int CTL_DINC = 5;
  localparam int SEL_GRP = 4;
  localparam int SEL_SWREQ = 5;
  localparam logic [WAIT_W-1:0] WAIT_RST = 2'h0;
  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RD = 4'b0010,
    ST_WR = 4'b0100,
    ST_GAP = 4'b1000
  } tcdma_fsm_type;
  typedef struct packed {
    logic [1:0][ADDR_W-1:0] src;
    logic [1:0][ADDR_W-1:0] dst;
    logic [1:0][ADDR_W-1:0] wptr;
    logic [1:0][CNT_W-1:0] rld;
    logic [1:0][CNT_W-1:0] cnt;
    logic [1:0][SEL_W-1:0] sel;
    logic [1:0] en, pend, word, rep, sinc, dinc, arm, prev, irq;
    logic [WAIT_W-1:0] waitst, wcnt;
    tcdma_fsm_type fsm;
    logic ch, beat, split, hold, rd, wr, byte_acc;
    logic [ADDR_W-1:0] xsrc, xdst, addr;
    logic [15:0] data, wdata;
  } tcdma_state_type;
endpackage

/* File: verilog/tcdma_core.sv */
// Two-channel cycle-steal DMA engine with APB register slave.
// Assumes the system arbiter yields the bus while bus_hold is high and
// pulses cpu_done for each completed CPU bus access.
`timescale 1ns/1ps
`default_nettype none
module tcdma_core
  import tcdma_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources, one vector per channel
  input wire logic [31:0] periph_req0,
  input wire logic [31:0] periph_req1,
  // System bus
  output logic bus_hold,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_byte,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ready,
  input wire logic ext_area,
  input wire logic expansion_mode,
  input wire logic external_width_pin,
  input wire logic cpu_done,
  // Counter underflow pulses
  output logic [1:0] dma_irq
);
  tcdma_state_type s_reg, s_next;

  // Peripheral line picked by group and select fields
  function automatic logic pick(input logic [31:0] v, input logic [SEL_W-1:0] sl);
    pick = v[sl];
  endfunction

  // Register decode shared by the read mux and the write path
  function automatic logic is_ch(input logic [7:0] a, input logic [4:0] off);
    is_ch = (a[7:6] == 2'b00) && (a[4:0] == off);
  endfunction

  // ----------------------------------------------------------------
  // Bus-facing signals
  // ----------------------------------------------------------------
  logic apb_wr, ch_a, both_inc, mapped, rdy_ok;
  logic [31:0] rmux;
  assign apb_wr = psel && penable && pwrite;
  assign ch_a = paddr[5];
  assign both_inc = pwdata[CTL_SINC] && pwdata[CTL_DINC];
  assign mapped = (paddr == {1'b0, OFF_WAIT}) ||
                  ((paddr[7:6] == 2'b00) && (paddr[4:0] <= OFF_PTR) && (paddr[1:0] == 2'b00));
  // Only external areas in expansion modes wait on ready
  assign rdy_ok = !(expansion_mode && ext_area) || mem_ready;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   (!mapped || (pwrite && is_ch(paddr, OFF_CTRL) && both_inc));
  assign prdata = psel ? rmux : 32'h0000_0000;
  assign bus_hold = s_reg.hold;
  assign mem_addr = s_reg.addr;
  assign mem_rd = s_reg.rd;
  assign mem_wr = s_reg.wr;
  assign mem_byte = s_reg.byte_acc;
  assign mem_wdata = s_reg.wdata;
  assign dma_irq = s_reg.irq;

  always_comb begin
    rmux = 32'h0000_0000;
    if (paddr == {1'b0, OFF_WAIT}) begin
      rmux[WAIT_W-1:0] = s_reg.waitst;
    end else if (is_ch(paddr, OFF_CTRL)) begin
      rmux[CTL_EN] = s_reg.en[ch_a];
      rmux[CTL_PEND] = s_reg.pend[ch_a];
      rmux[CTL_WORD] = s_reg.word[ch_a];
      rmux[CTL_REP] = s_reg.rep[ch_a];
      rmux[CTL_SINC] = s_reg.sinc[ch_a];
      rmux[CTL_DINC] = s_reg.dinc[ch_a];
    end else if (is_ch(paddr, OFF_SEL)) begin
      rmux[SEL_W-1:0] = s_reg.sel[ch_a];
    end else if (is_ch(paddr, OFF_SRC)) begin
      rmux[ADDR_W-1:0] = s_reg.src[ch_a];
    end else if (is_ch(paddr, OFF_DST)) begin
      rmux[ADDR_W-1:0] = s_reg.dst[ch_a];
    end else if (is_ch(paddr, OFF_RLD)) begin
      rmux[CNT_W-1:0] = s_reg.rld[ch_a];
    end else if (is_ch(paddr, OFF_CNT)) begin
      rmux[CNT_W-1:0] = s_reg.cnt[ch_a];
    end else if (is_ch(paddr, OFF_PTR)) begin
      rmux[ADDR_W-1:0] = s_reg.wptr[ch_a];
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic c;
    logic line;
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] step;
    c = 1'b0;
    line = 1'b0;
    a = '0;
    step = '0;
    s_next = s_reg;
    s_next.irq = 2'b00;
    case (s_reg.fsm)
      ST_IDLE: begin
        // Channel 0 first; nothing here reads or clears peripheral flags
        c = (s_reg.en[0] && s_reg.pend[0]) ? 1'b0 : 1'b1;
        if (s_reg.en[c] && s_reg.pend[c]) begin
          a = s_reg.arm[c] ? (s_reg.sinc[c] ? s_reg.src[c] : s_reg.dst[c])
                           : s_reg.wptr[c];
          if (s_reg.arm[c]) begin
            s_next.cnt[c] = s_reg.rld[c];
          end
          s_next.wptr[c] = a;
          s_next.arm[c] = 1'b0;
          s_next.pend[c] = 1'b0;
          s_next.ch = c;
          s_next.xsrc = s_reg.sinc[c] ? a : s_reg.src[c];
          s_next.xdst = s_reg.dinc[c] ? a : s_reg.dst[c];
          // Narrow bus applies to every area, internal included
          s_next.split = s_reg.word[c] &&
                         (external_width_pin || s_next.xsrc[0]);
          s_next.byte_acc = !s_reg.word[c] || s_next.split;
          s_next.addr = s_next.xsrc;
          s_next.rd = 1'b1;
          s_next.hold = 1'b1;
          s_next.beat = 1'b0;
          s_next.wcnt = s_reg.waitst;
          s_next.fsm = ST_RD;
        end
      end
      ST_RD: begin
        if (s_reg.wcnt != '0) begin
          s_next.wcnt = s_reg.wcnt - 1'b1;
        end else if (rdy_ok) begin
          if (s_reg.split && !s_reg.beat) begin
            s_next.data[7:0] = mem_rdata[7:0];
            s_next.beat = 1'b1;
            s_next.addr = s_reg.xsrc + 1'b1;
            s_next.wcnt = s_reg.waitst;
          end else begin
            if (s_reg.split) begin
              s_next.data[15:8] = mem_rdata[7:0];
            end else if (s_reg.word[s_reg.ch]) begin
              s_next.data = mem_rdata;
            end else begin
              s_next.data = {8'h00, mem_rdata[7:0]};
            end
            // Destination write follows the source read
            s_next.rd = 1'b0;
            s_next.wr = 1'b1;
            s_next.addr = s_reg.xdst;
            s_next.beat = 1'b0;
            s_next.wcnt = s_reg.waitst;
            s_next.split = s_reg.word[s_reg.ch] &&
                           (external_width_pin || s_reg.xdst[0]);
            s_next.byte_acc = !s_reg.word[s_reg.ch] || s_next.split;
            s_next.wdata = s_next.split ? {8'h00, s_next.data[7:0]} : s_next.data;
            s_next.fsm = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (s_reg.wcnt != '0) begin
          s_next.wcnt = s_reg.wcnt - 1'b1;
        end else if (rdy_ok) begin
          if (s_reg.split && !s_reg.beat) begin
            s_next.beat = 1'b1;
            s_next.addr = s_reg.xdst + 1'b1;
            s_next.wdata = {8'h00, s_reg.data[15:8]};
            s_next.wcnt = s_reg.waitst;
          end else begin
            c = s_reg.ch;
            s_next.wr = 1'b0;
            s_next.hold = 1'b0;
            s_next.byte_acc = 1'b0;
            step = s_reg.word[c] ? 20'h00002 : 20'h00001;
            s_next.wptr[c] = s_reg.wptr[c] + step;
            if (s_reg.cnt[c] == '0) begin
              s_next.irq[c] = 1'b1;
              if (s_reg.rep[c]) begin
                s_next.cnt[c] = s_reg.rld[c];
              end else begin
                s_next.cnt[c] = '1;
                s_next.en[c] = 1'b0;
              end
            end else begin
              s_next.cnt[c] = s_reg.cnt[c] - 1'b1;
            end
            s_next.fsm = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        // The CPU must get one bus access before the next steal
        if (cpu_done) begin
          s_next.fsm = ST_IDLE;
        end
      end
      default: begin
        s_next.fsm = ST_IDLE;
      end
    endcase
    // Register writes come after the engine so a fresh enable keeps its arm
    if (apb_wr) begin
      if (paddr == {1'b0, OFF_WAIT}) begin
        s_next.waitst = pwdata[WAIT_W-1:0];
      end else if (is_ch(paddr, OFF_CTRL)) begin
        s_next.en[ch_a] = pwdata[CTL_EN];
        s_next.arm[ch_a] = pwdata[CTL_EN] || (s_next.arm[ch_a] && s_reg.en[ch_a]);
        if (!pwdata[CTL_PEND]) begin
          s_next.pend[ch_a] = 1'b0;
        end
        s_next.word[ch_a] = pwdata[CTL_WORD];
        s_next.rep[ch_a] = pwdata[CTL_REP];
        if (!both_inc) begin
          s_next.sinc[ch_a] = pwdata[CTL_SINC];
          s_next.dinc[ch_a] = pwdata[CTL_DINC];
        end
      end else if (is_ch(paddr, OFF_SEL)) begin
        s_next.sel[ch_a] = pwdata[SEL_W-1:0];
      end else if (is_ch(paddr, OFF_SRC)) begin
        s_next.src[ch_a] = pwdata[ADDR_W-1:0];
      end else if (is_ch(paddr, OFF_DST)) begin
        s_next.dst[ch_a] = pwdata[ADDR_W-1:0];
      end else if (is_ch(paddr, OFF_RLD)) begin
        s_next.rld[ch_a] = pwdata[CNT_W-1:0];
      end
    end
    // Request sets come last so a set beats any clear in the same cycle
    for (int i = 0; i < 2; i++) begin
      line = pick(i == 0 ? periph_req0 : periph_req1, s_reg.sel[i]);
      s_next.prev[i] = line;
      // No interrupt mask is consulted; extra requests merge into pend
      if (line && !s_reg.prev[i]) begin
        s_next.pend[i] = 1'b1;
      end
      if (apb_wr && is_ch(paddr, OFF_SEL) && (ch_a == i[0]) && pwdata[SEL_SWREQ]) begin
        s_next.pend[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.fsm <= ST_IDLE;
      s_reg.waitst <= WAIT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_no_both_inc;
    !(s_reg.sinc[0] && s_reg.dinc[0]) && !(s_reg.sinc[1] && s_reg.dinc[1]);
  endproperty
  a_no_both_inc: assert property (p_no_both_inc) else $error("both pointers incrementing");

  property p_start_enabled;
    (s_reg.fsm == ST_IDLE) && (s_next.fsm == ST_RD) |-> s_reg.en[s_next.ch];
  endproperty
  a_start_enabled: assert property (p_start_enabled) else $error("start while disabled");

  property p_prio;
    (s_reg.fsm == ST_IDLE) && (&s_reg.en) && (&s_reg.pend) |=> (s_reg.ch == 1'b0) && mem_rd;
  endproperty
  a_prio: assert property (p_prio) else $error("channel 1 beat channel 0");

  property p_rd_wr;
    (s_reg.fsm == ST_RD) && (s_next.fsm != ST_RD) |=> mem_wr && !mem_rd;
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");

  property p_release;
    (s_reg.fsm == ST_WR) && (s_next.fsm == ST_GAP) |=> !bus_hold ##1 (!mem_rd || $past(cpu_done));
  endproperty
  a_release: assert property (p_release) else $error("bus not handed back");

  property p_wait;
    $rose(mem_rd) && (s_reg.waitst == 2'h2) |-> mem_rd [*3];
  endproperty
  a_wait: assert property (p_wait) else $error("wait states not inserted");

  property p_irq_cause;
    dma_irq[0] |-> $past(s_reg.cnt[0]) == '0 && $past(s_reg.fsm) == ST_WR;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without underflow");

  property p_pend_set;
    psel && penable && pwrite && (paddr == {3'b000, OFF_SEL}) && pwdata[SEL_SWREQ]
      |=> s_reg.pend[0] || (s_reg.fsm == ST_RD);
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("software request lost");

  property p_single_stop;
    dma_irq[0] && !$past(s_reg.rep[0]) && !$past(apb_wr) |-> !s_reg.en[0];
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single run kept going");

  property p_split;
    $rose(mem_rd) && mem_byte && s_reg.word[s_reg.ch] && (s_reg.waitst == '0) && rdy_ok
      |=> mem_rd && (mem_addr == $past(mem_addr) + 1'b1);
  endproperty
  a_split: assert property (p_split) else $error("word not split into bytes");

  property p_wr_split;
    (s_reg.fsm == ST_WR) && s_reg.split && !s_reg.beat && (s_reg.wcnt == '0) && rdy_ok
      |=> mem_wr && mem_byte && (mem_addr == $past(mem_addr) + 1'b1);
  endproperty
  a_wr_split: assert property (p_wr_split) else $error("write not split into bytes");

  property p_gap_hold;
    (s_reg.fsm == ST_GAP) && !cpu_done |=> (s_reg.fsm == ST_GAP) && !bus_hold;
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("steal before CPU access");

  property p_reload;
    dma_irq[1] && $past(s_reg.rep[1]) |-> s_reg.cnt[1] == $past(s_reg.rld[1]);
  endproperty
  a_reload: assert property (p_reload) else $error("repeat run not reloaded");

  property p_irq_cause1;
    dma_irq[1] |-> $past(s_reg.cnt[1]) == '0 && $past(s_reg.fsm) == ST_WR;
  endproperty
  a_irq_cause1: assert property (p_irq_cause1) else $error("stray interrupt on channel 1");

  c_repeat: cover property (dma_irq[1] && s_reg.en[1]);
  c_wait: cover property (mem_rd && (s_reg.wcnt != '0));
  c_both: cover property ((&s_reg.pend) && (&s_reg.en) && (s_reg.fsm == ST_IDLE));
  c_split: cover property (s_reg.split && s_reg.beat && mem_wr);
endmodule
`default_nettype wire

/* File: tb/tcdma_mem_model.sv */
// CPU side and memory model for the DMA bench.
// Assumes an 8-bit address window and byte beats on bits 7:0.
`timescale 1ns/1ps
`default_nettype none
module tcdma_mem_model
  import tcdma_pkg::*;
#(
  parameter int READY_DLY = 2
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Engine bus
  input wire logic bus_hold,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic mem_byte,
  input wire logic [15:0] mem_wdata,
  // Answers
  output logic [15:0] mem_rdata,
  output logic mem_ready,
  output logic cpu_done
);
  logic [7:0] m [256];
  logic [7:0] a;
  logic [3:0] rc;
  logic [3:0] gap;
  logic [15:0] last;
  logic hq;
  assign a = mem_addr[7:0];
  assign mem_ready = rc >= 4'(READY_DLY);
  // Idle bus shows inverted old data, so a stale sample cannot match
  assign mem_rdata = mem_rd ? {mem_byte ? ~m[a] : m[a+8'h01], m[a]} : ~last;
  initial begin
    for (int i = 0; i < 256; i++) begin
      m[i] = 8'(i) ^ 8'ha5;
    end
  end
  // ------------------------------------------------------------
  // Slow ready, and one CPU access after every bus release
  // ------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rc <= 4'h0;
      gap <= 4'h0;
      last <= 16'h0;
      hq <= 1'b0;
      cpu_done <= 1'b0;
    end else begin
      hq <= bus_hold;
      rc <= ((mem_rd || mem_wr) && !mem_ready) ? rc + 4'h1 : 4'h0;
      gap <= (hq && !bus_hold) ? 4'h3 : ((gap != 4'h0) ? gap - 4'h1 : 4'h0);
      cpu_done <= (gap == 4'h1);
      if (mem_rd) last <= mem_rdata;
      if (mem_wr) begin
        m[a] <= mem_wdata[7:0];
        if (!mem_byte) m[a+8'h01] <= mem_wdata[15:8];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the two-channel DMA engine.
// Assumes the memory model answers on the system bus side.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tcdma_pkg::*;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, periph_req0, periph_req1;
  logic bus_hold, mem_rd, mem_wr, mem_byte, mem_ready, cpu_done;
  logic ext_area, expansion_mode, external_width_pin, hq, wq;
  logic [ADDR_W-1:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [1:0] dma_irq;
  int bad_count, checked, rd_n, wr_n, hf_n;
  int irq_n [2];
  logic [7:0] wlog [$];
  tcdma_core tcdma_core_i (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periph_req0, .periph_req1, .bus_hold, .mem_addr,
    .mem_rd, .mem_wr, .mem_byte, .mem_wdata, .mem_rdata, .mem_ready, .ext_area,
    .expansion_mode, .external_width_pin, .cpu_done, .dma_irq);
  tcdma_mem_model #(.READY_DLY(2)) tcdma_mem_model_i (.mclk, .resetn, .bus_hold,
    .mem_addr, .mem_rd, .mem_wr, .mem_byte, .mem_wdata, .mem_rdata, .mem_ready,
    .cpu_done);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (mem_rd === 1'b1) rd_n++;
    if (mem_wr === 1'b1) wr_n++;
    if (dma_irq[0] === 1'b1) irq_n[0]++;
    if (dma_irq[1] === 1'b1) irq_n[1]++;
    if (mem_wr === 1'b1 && wq !== 1'b1) wlog.push_back(mem_addr[7:0]);
    if (bus_hold !== 1'b1 && hq === 1'b1) hf_n++;
    hq <= bus_hold;
    wq <= mem_wr;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [7:0] i);
    return i ^ 8'ha5;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps the next call from re-driving psel in this time step
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask
  task automatic waitx(input int k);
    for (int n = 0; n < 300 && hf_n < k; n++) @(posedge mclk);
    if (hf_n < k) begin
      bad_count++;
      close_out();
    end
    repeat (8) @(posedge mclk);
  endtask
  task automatic cfg(input logic [7:0] b, input logic [7:0] s, input logic [7:0] d,
                     input logic [31:0] rl, input logic [31:0] c);
    wr(b + 8'h08, {24'h0, s});
    wr(b + 8'h0c, {24'h0, d});
    wr(b + 8'h10, rl);
    wr(b, c);
  endtask
  task automatic go(input logic [7:0] b);
    int k;
    k = hf_n + 1;
    wr(b + 8'h04, 32'h20);
    waitx(k);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_regs;
    logic [31:0] r;
    logic e;
    rdc(8'h00, 32'h0, "ctrl reset");
    rdc(8'h40, 32'h0, "wait reset");
    apb(1'b0, 8'h7c, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    apb(1'b1, 8'h00, 32'h30, r, e);
    chk("both inc error", 32'h1, {31'h0, e});
    rdc(8'h00, 32'h0, "both inc kept");
  endtask
  task automatic sc_pending;
    wr(8'h04, 32'h20);
    repeat (3) @(posedge mclk);
    rdc(8'h00, 32'h2, "pending while off");
    chk("no transfer while off", 32'h0, 32'(hf_n));
    wr(8'h00, 32'h0);
    rdc(8'h00, 32'h0, "pending cleared");
  endtask
  task automatic sc_single;
    // Pointers stay clear of the controller's own register window
    cfg(8'h00, 8'h80, 8'hc0, 32'h1, 32'h11);
    go(8'h00);
    rdc(8'h18, 32'h81, "pointer step");
    rdc(8'h14, 32'h0, "count step");
    chk("no early irq", 32'h0, 32'(irq_n[0]));
    chk("first byte", {24'h0, pat(8'h80)}, {24'h0, tcdma_mem_model_i.m[8'hc0]});
    go(8'h00);
    chk("second byte", {24'h0, pat(8'h81)}, {24'h0, tcdma_mem_model_i.m[8'hc0]});
    chk("underflow irq", 32'h1, 32'(irq_n[0]));
    rdc(8'h14, 32'hffff, "count underflow");
    rdc(8'h00, 32'h10, "single stops");
    wr(8'h04, 32'h20);
    repeat (20) @(posedge mclk);
    chk("stopped channel idle", 32'h2, 32'(hf_n));
  endtask
  task automatic sc_dinc;
    cfg(8'h00, 8'h86, 8'he0, 32'h0, 32'h25);
    go(8'h00);
    rdc(8'h18, 32'he2, "dst pointer step");
    chk("dst inc low", {24'h0, pat(8'h86)}, {24'h0, tcdma_mem_model_i.m[8'he0]});
    chk("dst inc high", {24'h0, pat(8'h87)}, {24'h0, tcdma_mem_model_i.m[8'he1]});
    chk("dst inc irq", 32'h2, 32'(irq_n[0]));
    rdc(8'h00, 32'h24, "dst run stops");
  endtask
  task automatic cs(input logic w, input logic [7:0] s, input logic [7:0] d, input logic nar,
                    input logic [1:0] wt, input logic ext, input int er, input int ew);
    int r0, w0, i0;
    logic [7:0] s1, d1;
    external_width_pin <= nar;
    ext_area <= ext;
    expansion_mode <= ext;
    wr(8'h40, {30'h0, wt});
    cfg(8'h20, s, d, 32'h0, w ? 32'hd : 32'h9);
    r0 = rd_n;
    w0 = wr_n;
    i0 = irq_n[1];
    go(8'h20);
    chk("read cycles", 32'(er), 32'(rd_n - r0));
    chk("write cycles", 32'(ew), 32'(wr_n - w0));
    chk("moved byte", {24'h0, pat(s)}, {24'h0, tcdma_mem_model_i.m[d]});
    s1 = s + 8'h01;
    d1 = d + 8'h01;
    if (w) begin
      chk("high byte", {24'h0, pat(s1)}, {24'h0, tcdma_mem_model_i.m[d1]});
    end
    chk("reload irq", 32'(i0 + 1), 32'(irq_n[1]));
  endtask
  task automatic sc_prio;
    int k;
    external_width_pin <= 1'b0;
    ext_area <= 1'b0;
    expansion_mode <= 1'b0;
    wr(8'h04, 32'h03);
    wr(8'h24, 32'h13);
    cfg(8'h00, 8'h90, 8'hd0, 32'h3, 32'h1);
    cfg(8'h20, 8'h91, 8'hd1, 32'h0, 32'h9);
    wlog.delete();
    k = hf_n + 2;
    periph_req0[3] <= 1'b1;
    periph_req1[19] <= 1'b1;
    repeat (2) @(posedge mclk);
    periph_req1[19] <= 1'b0;
    @(posedge mclk);
    periph_req1[19] <= 1'b1;
    waitx(k);
    repeat (20) @(posedge mclk);
    chk("merged requests", 32'(k), 32'(hf_n));
    chk("first served", 32'hd0, {24'h0, wlog[0]});
    chk("second served", 32'hd1, {24'h0, wlog[1]});
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    periph_req0 = 32'h0;
    periph_req1 = 32'h0;
    ext_area = 1'b0;
    expansion_mode = 1'b0;
    external_width_pin = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    sc_regs();
    sc_pending();
    sc_single();
    sc_dinc();
    cs(1'b0, 8'h85, 8'hc0, 1'b0, 2'h0, 1'b0, 1, 1);
    cs(1'b1, 8'h80, 8'hc0, 1'b0, 2'h0, 1'b0, 1, 1);
    cs(1'b1, 8'h81, 8'hc0, 1'b0, 2'h0, 1'b0, 2, 1);
    cs(1'b1, 8'h80, 8'hc1, 1'b0, 2'h0, 1'b0, 1, 2);
    cs(1'b1, 8'h84, 8'hc0, 1'b1, 2'h0, 1'b0, 2, 2);
    cs(1'b0, 8'h82, 8'hc0, 1'b0, 2'h2, 1'b0, 3, 3);
    cs(1'b0, 8'h83, 8'hc0, 1'b0, 2'h0, 1'b1, 3, 3);
    rdc(8'h20, 32'h9, "repeat stays on");
    sc_prio();
    close_out();
  end
endmodule
`default_nettype wire
